// >>> bench/eeprom_byte_access_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
// ==========================================================
// Both ends joined, driven from the host APB side.
module eeprom_byte_access_ctrl_test;
  import nv_pkg::*;
  localparam int unsigned WRC = 200;
  logic        pclk, presetn, por_n, psel, penable, pwrite, spm_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq_out, er;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  nv_io_if nv_io_if_i (.pclk(pclk));
  nv_access_dev #(.WR_CYCLES(WRC)) nv_access_dev_i (.pclk(pclk),
    .presetn(presetn), .por_n(por_n), .io(nv_io_if_i));
  nv_core_host nv_core_host_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spm_in(spm_in), .irq_out(irq_out),
    .io(nv_io_if_i));
  nv_link_sva #(.WR_CYCLES(WRC)) nv_link_sva_i (.pclk(pclk),
    .presetn(presetn), .por_n(por_n), .io_addr(nv_io_if_i.io_addr),
    .io_wr(nv_io_if_i.io_wr), .io_rd(nv_io_if_i.io_rd),
    .io_wdata(nv_io_if_i.io_wdata), .io_rdata(nv_io_if_i.io_rdata),
    .stall(nv_io_if_i.stall), .irq(nv_io_if_i.irq),
    .global_ie(nv_io_if_i.global_ie), .spm_busy(nv_io_if_i.spm_busy));
  // Clock at 10 MHz and a free cycle count.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  // ========================================================
  // Reporting.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk
  // ========================================================
  // Bus tasks; each starts just after a rising edge.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(k < 20), 32'h1);
    if (k >= 20) give_verdict();
    @(posedge pclk);
  endtask : xfer
  // Runs one command and polls until it is done.
  task automatic nv_op(input logic [8:0] i, input logic [7:0] v,
                       input logic w);
    int k = 0;
    xfer(`H_ADDR_OFS, 1'b1, {23'h0, i});
    if (w) xfer(`H_WDATA_OFS, 1'b1, {24'h0, v});
    xfer(`H_CMD_OFS, 1'b1, w ? 32'h2 : 32'h1);
    do begin
      xfer(`H_STAT_OFS, 1'b0, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 3000);
    chk(32'(k < 3000), 32'h1);
    if (k >= 3000) give_verdict();
  endtask : nv_op
  // ========================================================
  // Scenarios.
  task automatic t_regs();
    xfer(`H_STAT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(8'h14, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("regs test done");
  endtask : t_regs
  task automatic t_edges();
    logic [8:0] ix [4] = '{9'h000, 9'h1FF, 9'h0FF, 9'h100};
    logic [7:0] vl [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    for (int i = 0; i < 4; i++) nv_op(ix[i], vl[i], 1'b1);
    for (int i = 0; i < 4; i++) begin
      nv_op(ix[i], 8'h00, 1'b0);
      chk(rd[15:8], vl[i]);
    end
    $display("edges test done");
  endtask : t_edges
  task automatic t_timing();
    int c0 = cyc;
    nv_op(9'h055, 8'h99, 1'b1);
    xfer(`H_STAT_OFS, 1'b0, 32'h0);
    chk(rd[1], 1'b1);
    // Sleep stays off while the last write is not seen finished.
    xfer(`H_CFG_OFS, 1'b1, 32'h4);
    xfer(`H_STAT_OFS, 1'b0, 32'h0);
    chk(rd[2], 1'b0);
    nv_op(9'h055, 8'h00, 1'b0);
    chk(rd[15:8], 8'h99);
    xfer(`H_STAT_OFS, 1'b0, 32'h0);
    chk(rd[3:2], 2'h1);
    xfer(`H_CFG_OFS, 1'b1, 32'h0);
    chk(32'(cyc - c0 >= WRC), 32'h1);
    chk(32'(cyc - c0 < WRC + 150), 32'h1);
    $display("timing test done");
  endtask : t_timing
  task automatic t_spm();
    int c0 = cyc;
    int c1 = 0;
    spm_in <= 1'b1;
    fork
      begin
        nv_op(9'h0A0, 8'hC3, 1'b1);
        c1 = cyc;
      end
      begin
        repeat (80) @(posedge pclk);
        spm_in <= 1'b0;
      end
    join
    chk(32'(c1 - c0 >= 80), 32'h1);
    nv_op(9'h0A0, 8'h00, 1'b0);
    chk(rd[15:8], 8'hC3);
    $display("flash interlock test done");
  endtask : t_spm
  task automatic t_reset();
    nv_op(9'h0AA, 8'h5A, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    nv_op(9'h0AA, 8'h00, 1'b0);
    chk(rd[15:8], 8'h5A);
    $display("reset test done");
  endtask : t_reset
  task automatic t_irq();
    logic [1:0] cf [3] = '{2'h3, 2'h2, 2'h1};
    logic       ex [3] = '{1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 3; i++) begin
      xfer(`H_CFG_OFS, 1'b1, {30'h0, cf[i]});
      nv_op(9'h000, 8'h00, 1'b0);
      repeat (4) @(posedge pclk);
      chk(irq_out, ex[i]);
    end
    $display("interrupt test done");
  endtask : t_irq
  // Main sequence.
  initial begin
    presetn = 1'b0;
    por_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    spm_in  = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_edges();
    t_timing();
    t_spm();
    t_reset();
    t_irq();
    give_verdict();
  end
endmodule : eeprom_byte_access_ctrl_test
`default_nettype wire

// >>> bench/nv_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
// ==========================================================
// Checker for the core I/O link between the two ends.
module nv_link_sva
  import nv_pkg::*;
#(
  parameter int unsigned WR_CYCLES = 20  // Write length in clocks.
) (
  input wire logic             pclk,      // Clock.
  input wire logic             presetn,   // Reset, active low.
  input wire logic             por_n,     // Power-on reset, active low.
  input wire nv_pkg::io_addr_t io_addr,   // Register offset.
  input wire logic             io_wr,     // Register write.
  input wire logic             io_rd,     // Register read.
  input wire nv_pkg::byte_t    io_wdata,  // Write data.
  input wire nv_pkg::byte_t    io_rdata,  // Read data.
  input wire logic             stall,     // Core stall.
  input wire logic             irq,       // Ready interrupt.
  input wire logic             global_ie, // Global enable.
  input wire logic             spm_busy   // Flash self-programming.
);
  logic        ctl_wr;
  logic        go;
  logic [2:0]  arm_ff;
  logic        rie_ff;
  int unsigned wcnt_ff;
  // A strobe counts only inside the arm window and while idle.
  assign ctl_wr = io_wr && io_addr == `NV_CTRL_OFS;
  assign go = ctl_wr && io_wdata[1] && arm_ff != 3'h0 && wcnt_ff == 0
              && !spm_busy;
  // Arm window covers the four edges after the arm write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) arm_ff <= 3'h0;
    else if (ctl_wr && io_wdata[2] && !io_wdata[1]) arm_ff <= 3'h4;
    else if (arm_ff != 3'h0) arm_ff <= arm_ff - 3'h1;
  end
  // Interrupt enable follows every control write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rie_ff <= 1'b0;
    else if (ctl_wr) rie_ff <= io_wdata[3];
  end
  // Write time survives a system reset, so only power-on clears it.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) wcnt_ff <= 0;
    else if (go) wcnt_ff <= WR_CYCLES;
    else if (wcnt_ff != 0) wcnt_ff <= wcnt_ff - 1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rd_stall_a: assert property (
    ctl_wr && io_wdata[0] && wcnt_ff == 0 |=> stall [*4] ##1 !stall)
    else $error("read stall length wrong");
  wr_stall_a: assert property (
    go |=> stall [*2] ##1 !stall)
    else $error("write stall length wrong");
  no_arm_a: assert property (
    ctl_wr && io_wdata[1] && arm_ff == 3'h0 && !stall |=> !stall)
    else $error("strobe without arm acted");
  spm_block_a: assert property (
    ctl_wr && io_wdata[1] && spm_busy && !stall |=> !stall)
    else $error("write started during flash programming");
  rd_bit_a: assert property (
    io_rd && io_addr == `NV_CTRL_OFS
    |=> io_rdata[0] == 1'b0 && io_rdata[7:4] == 4'h0)
    else $error("read strobe or reserved bits read set");
  busy_rd_a: assert property (
    io_rd && io_addr == `NV_CTRL_OFS && wcnt_ff > 3
    && wcnt_ff < WR_CYCLES - 3 |=> io_rdata[1])
    else $error("busy not seen during write");
  rdata_hold_a: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  irq_off_a: assert property (
    wcnt_ff > 2 |-> !irq)
    else $error("ready interrupt during write");
  irq_on_a: assert property (
    (rie_ff && global_ie && wcnt_ff == 0) [*3] |-> irq)
    else $error("ready interrupt missing");
  // Main scenarios seen at least once.
  wr_go_c: cover property (go);
  rd_go_c: cover property (ctl_wr && io_wdata[0]);
  irq_c: cover property (irq);
endmodule : nv_link_sva
`default_nettype wire

// >>> src/nv_access_dev.sv
// Summary of operation
// - 512 single-byte readable and writable locations.
// - Index, value, control registers in I/O space.
// - Read stalls the core four cycles.
// - Write start stalls the core two cycles.
// - Software waits for busy clear before writing.
// - Software waits self-programming idle before writing.
// - Index and value loads, any order.
// - Arm, then strobe within four cycles.
// - No write while flash self-programs.
// - Expired arm window means no write.
// - Live index and value; corruption fails access.
// - Software keeps interrupts off during sequence.
// - Hardware clears busy when write time ends.
// - Busy blocks reads and index changes.
// - Software checks busy clear before reading.
// - Write lasts 27072 oscillator cycles, about 3.3ms.
// - Write completes in sleep; clock then keeps running.
// - Software confirms write done before sleeping.
// - Write finishes across a reset.
// - Arm self-clears after four cycles; strobe needs it.
// - Nine-bit linear index, loaded before use.
// - Read puts addressed byte into value register.
// - Ready interrupt level while busy clear.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
module nv_access_dev #(
  parameter int unsigned WR_CYCLES = `NV_WR_OSC_CYC  // Write length.
) (
  input  wire logic pclk,    // Core clock, 10 MHz.
  input  wire logic presetn, // System reset, active low.
  input  wire logic por_n,   // Power-on reset, active low.
  nv_io_if.dev      io       // Core I/O link.
);
  import nv_pkg::*;

  // ========================================================
  // Storage and registers.
  byte_t  mem [`NV_DEPTH];
  index_t index_ff;
  byte_t  value_ff;
  byte_t  rdata_ff;
  logic   arm_ff;
  logic   rie_ff;
  logic [2:0] arm_cnt_ff;
  logic [2:0] stall_cnt_ff;
  logic   stall_ff;
  logic   irq_ff;
  logic   pdb_ff;
  logic   wbusy;
  logic   wdone;
  logic   ctrl_wr;
  logic   rd_go;
  logic   wr_go;

  assign io.io_rdata   = rdata_ff;
  assign io.stall      = stall_ff;
  assign io.irq        = irq_ff;
  assign io.pd_blocked = pdb_ff;

  // ========================================================
  // Register hit: a core write aimed at one I/O offset.
  function automatic logic reg_wr(input logic     wr,
                                  input io_addr_t addr,
                                  input io_addr_t ofs);
    return wr && (addr == ofs);
  endfunction : reg_wr

  // ========================================================
  // Decoding of control writes.
  // Read and strobe bits of a control write act only in the cycle it is taken; arm and interrupt enable are held.
  assign ctrl_wr = reg_wr(io.io_wr, io.io_addr, `NV_CTRL_OFS);
  // A read is honoured only while no write runs.
  assign rd_go = ctrl_wr && io.io_wdata[`NV_RD_BIT] && !wbusy;
  // A strobe starts a write only when armed, idle and flash quiet.
  assign wr_go = ctrl_wr && io.io_wdata[`NV_WBUSY_BIT] && arm_ff
                 && !wbusy && !io.spm_busy;

  // ========================================================
  // Write duration timer, kept alive across system reset.
  // Only power-on stops a write that is under way.
  nv_write_timer #(
    .WR_CYCLES (WR_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .por_n   (por_n),
    .start   (wr_go),
    .busy_ff (wbusy),
    .done_ff (wdone)
  );

  // ========================================================
  // Index and value registers, on power-on reset so an
  // in-flight write still finds its target after a reset.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      index_ff <= `NV_IDX_RST;
      value_ff <= `NV_VALUE_RST;
    end else begin
      if (io.io_wr && !wbusy) begin
        // Index is frozen while a write runs.
        if (io.io_addr == `NV_IDX_LO_OFS) begin
          index_ff[7:0] <= io.io_wdata;
        end
        if (io.io_addr == `NV_IDX_HI_OFS) begin
          index_ff[8] <= io.io_wdata[0];
        end
      end
      if (rd_go) begin
        value_ff <= mem[index_ff];
      end else if (reg_wr(io.io_wr, io.io_addr, `NV_VALUE_OFS)) begin
        value_ff <= io.io_wdata;
      end
    end
  end

  // Commits the live value register at the end of the write.
  // The array has no reset, so unwritten bytes read as unknown.
  always_ff @(posedge pclk) begin
    if (wdone) begin
      mem[index_ff] <= value_ff;
    end
  end

  // ========================================================
  // Arm bit with its four-cycle window, and interrupt enable.
  // A write that sets arm and strobe together does not arm.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff     <= 1'b0;
      arm_cnt_ff <= 3'h0;
      rie_ff     <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        rie_ff <= io.io_wdata[`NV_RIE_BIT];
      end
      if (ctrl_wr && io.io_wdata[`NV_ARM_BIT]
          && !io.io_wdata[`NV_WBUSY_BIT]) begin
        arm_ff     <= 1'b1;
        arm_cnt_ff <= `NV_ARM_CYCLES;
      end else if (wr_go) begin
        arm_ff     <= 1'b0;
        arm_cnt_ff <= 3'h0;
      end else if (arm_ff) begin
        if (arm_cnt_ff == 3'h1) begin
          arm_ff <= 1'b0;
        end
        arm_cnt_ff <= arm_cnt_ff - 3'h1;
      end
    end
  end

  // ========================================================
  // Core stall after a read or a write start.
  // The core issues nothing while stalled, so no strobe restarts it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_ff <= 3'h0;
      stall_ff     <= 1'b0;
    end else if (rd_go) begin
      stall_cnt_ff <= `NV_RD_STALL - 3'h1;
      stall_ff     <= 1'b1;
    end else if (wr_go) begin
      stall_cnt_ff <= `NV_WR_STALL - 3'h1;
      stall_ff     <= 1'b1;
    end else if (stall_cnt_ff != 3'h0) begin
      stall_cnt_ff <= stall_cnt_ff - 3'h1;
      stall_ff     <= 1'b1;
    end else begin
      stall_ff <= 1'b0;
    end
  end

  // ========================================================
  // Register read-back; the read strobe always reads as zero.
  // Data stands from the edge after the read until the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 8'h00;
    end else if (io.io_rd) begin
      unique case (io.io_addr)
        `NV_CTRL_OFS:   rdata_ff <= {4'h0, rie_ff, arm_ff,
                                     wbusy, 1'b0};
        `NV_VALUE_OFS:  rdata_ff <= value_ff;
        `NV_IDX_LO_OFS: rdata_ff <= index_ff[7:0];
        `NV_IDX_HI_OFS: rdata_ff <= {7'h00, index_ff[8]};
        default:        rdata_ff <= 8'h00;
      endcase
    end
  end

  // ========================================================
  // Ready interrupt level and power-down blocking flag.
  // The level trails the busy flag by one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
      pdb_ff <= 1'b0;
    end else begin
      irq_ff <= rie_ff && io.global_ie && !wbusy;
      if (!io.sleep_pd) begin
        pdb_ff <= 1'b0;
      end else if (wdone) begin
        pdb_ff <= 1'b1;
      end
    end
  end
endmodule : nv_access_dev
`default_nettype wire

// >>> src/nv_core_host.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
// ==========================================================
// Processor-side sequencer driven by APB command registers.
module nv_core_host (
  input  wire logic        pclk,      // Core clock.
  input  wire logic        presetn,   // Reset, active low.
  input  wire logic        psel,      // APB select.
  input  wire logic        penable,   // APB enable.
  input  wire logic        pwrite,    // APB direction.
  input  wire logic [7:0]  paddr,     // APB byte address.
  input  wire logic [31:0] pwdata,    // APB write data.
  output logic      [31:0] prdata,    // APB read data.
  output logic             pready,    // APB ready.
  output logic             pslverr,   // APB error, unmapped.
  input  wire logic        spm_in,    // Flash self-programming busy.
  output logic             irq_out,   // Ready interrupt seen.
  nv_io_if.core            io         // Link to the device.
);
  import nv_pkg::*;

  host_state_t st_ff;
  logic        is_wr_ff;
  logic        busy_seen_ff;
  logic        cmd_busy_ff;
  index_t      addr_ff;
  byte_t       wdata_ff;
  byte_t       rdata_ff;
  logic [2:0]  cfg_ff;
  logic        rdy_ff;
  logic        err_ff;
  logic [31:0] prd_ff;
  logic        io_wr_ff;
  logic        io_rd_ff;
  io_addr_t    io_addr_ff;
  byte_t       io_wd_ff;
  logic        gie_ff;
  logic        spm_ff;
  logic        slp_ff;
  logic        irq_ff;
  logic        acc;
  logic        mapped;

  assign prdata      = prd_ff;
  assign pready      = rdy_ff;
  assign pslverr     = err_ff;
  assign irq_out     = irq_ff;
  assign io.io_wr    = io_wr_ff;
  assign io.io_rd    = io_rd_ff;
  assign io.io_addr  = io_addr_ff;
  assign io.io_wdata = io_wd_ff;
  assign io.global_ie = gie_ff;
  assign io.spm_busy = spm_ff;
  assign io.sleep_pd = slp_ff;

  // ========================================================
  // APB slave: one wait-free access cycle, error on holes.
  assign acc    = psel && penable && rdy_ff;
  assign mapped = paddr inside {`H_CMD_OFS, `H_ADDR_OFS, `H_WDATA_OFS,
                                `H_STAT_OFS, `H_CFG_OFS};

  // Answers each setup cycle with ready in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      prd_ff <= 32'h0000_0000;
    end else begin
      rdy_ff <= psel && !penable;
      err_ff <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `H_ADDR_OFS:  prd_ff <= {23'h0, addr_ff};
          `H_WDATA_OFS: prd_ff <= {24'h0, wdata_ff};
          `H_STAT_OFS:  prd_ff <= {16'h0, rdata_ff, 4'h0, io.pd_blocked,
                                   slp_ff, busy_seen_ff, cmd_busy_ff};
          `H_CFG_OFS:   prd_ff <= {29'h0, cfg_ff};
          default:      prd_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Holds software settings; ignored while a command runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff  <= `NV_IDX_RST;
      wdata_ff <= `NV_VALUE_RST;
      cfg_ff   <= 3'h0;
    end else if (acc && pwrite && !cmd_busy_ff) begin
      if (paddr == `H_ADDR_OFS)  addr_ff  <= pwdata[8:0];
      if (paddr == `H_WDATA_OFS) wdata_ff <= pwdata[7:0];
      if (paddr == `H_CFG_OFS)   cfg_ff   <= pwdata[2:0];
    end
  end

  // ========================================================
  // Access sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff        <= H_IDLE;
      is_wr_ff     <= 1'b0;
      cmd_busy_ff  <= 1'b0;
      busy_seen_ff <= 1'b0;
      rdata_ff     <= 8'h00;
      io_wr_ff     <= 1'b0;
      io_rd_ff     <= 1'b0;
      io_addr_ff   <= 6'h00;
      io_wd_ff     <= 8'h00;
    end else begin
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      unique case (st_ff)
        H_IDLE: begin
          if (acc && pwrite && paddr == `H_CMD_OFS
              && (pwdata[`H_CMD_RD_BIT] || pwdata[`H_CMD_WR_BIT])) begin
            is_wr_ff    <= pwdata[`H_CMD_WR_BIT];
            cmd_busy_ff <= 1'b1;
            st_ff       <= H_POLL;
          end
        end
        H_POLL: begin
          io_rd_ff   <= 1'b1;
          io_addr_ff <= `NV_CTRL_OFS;
          st_ff      <= H_PCAP;
        end
        H_PCAP: begin
          // The edge that takes the read is skipped; data stands after it.
          if (!io_rd_ff) begin
            busy_seen_ff <= io.io_rdata[`NV_WBUSY_BIT];
            if (io.io_rdata[`NV_WBUSY_BIT]) begin
              st_ff <= H_POLL;
            end else begin
              st_ff <= is_wr_ff ? H_SPM : H_ILO;
            end
          end
        end
        H_SPM: begin
          if (!spm_ff) st_ff <= H_ILO;
        end
        H_ILO: begin
          io_wr_ff   <= 1'b1;
          io_addr_ff <= `NV_IDX_LO_OFS;
          io_wd_ff   <= addr_ff[7:0];
          st_ff      <= H_IHI;
        end
        H_IHI: begin
          io_wr_ff   <= 1'b1;
          io_addr_ff <= `NV_IDX_HI_OFS;
          io_wd_ff   <= {7'h00, addr_ff[8]};
          st_ff      <= is_wr_ff ? H_DATA : H_RSTB;
        end
        H_DATA: begin
          io_wr_ff   <= 1'b1;
          io_addr_ff <= `NV_VALUE_OFS;
          io_wd_ff   <= wdata_ff;
          st_ff      <= H_ARM;
        end
        H_ARM: begin
          io_wr_ff   <= 1'b1;
          io_addr_ff <= `NV_CTRL_OFS;
          io_wd_ff   <= 8'(1 << `NV_ARM_BIT)
                        | {4'h0, cfg_ff[`H_CFG_RIE_BIT], 3'h0};
          st_ff      <= H_GO;
        end
        H_GO: begin
          io_wr_ff   <= 1'b1;
          io_wd_ff   <= 8'(1 << `NV_WBUSY_BIT)
                        | {4'h0, cfg_ff[`H_CFG_RIE_BIT], 3'h0};
          st_ff      <= H_HOLD;
        end
        H_RSTB: begin
          io_wr_ff   <= 1'b1;
          io_addr_ff <= `NV_CTRL_OFS;
          io_wd_ff   <= 8'(1 << `NV_RD_BIT)
                        | {4'h0, cfg_ff[`H_CFG_RIE_BIT], 3'h0};
          st_ff      <= H_HOLD;
        end
        H_HOLD: begin
          // Skips the edge that takes the strobe, then waits out its stall.
          if (!io_wr_ff && !io.stall) begin
            busy_seen_ff <= is_wr_ff;
            cmd_busy_ff  <= !is_wr_ff;
            st_ff        <= is_wr_ff ? H_IDLE : H_RVAL;
          end
        end
        H_RVAL: begin
          io_rd_ff   <= 1'b1;
          io_addr_ff <= `NV_VALUE_OFS;
          st_ff      <= H_RCAP;
        end
        H_RCAP: begin
          if (!io_rd_ff) begin
            rdata_ff    <= io.io_rdata;
            cmd_busy_ff <= 1'b0;
            st_ff       <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ========================================================
  // Interrupt gating, flash-busy pass-through and sleep entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_ff <= 1'b0;
      spm_ff <= 1'b0;
      slp_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      gie_ff <= cfg_ff[`H_CFG_GIE_BIT] && !cmd_busy_ff;
      spm_ff <= spm_in;
      irq_ff <= io.irq;
      // Sleep only after a poll has shown the write finished.
      slp_ff <= cfg_ff[`H_CFG_SLP_BIT] && !cmd_busy_ff
                && (slp_ff || !busy_seen_ff);
    end
  end
endmodule : nv_core_host
`default_nettype wire

// >>> src/nv_io_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Core I/O link between the processor end and the nonvolatile end.
interface nv_io_if (
  input wire logic pclk  // Shared core clock.
);
  import nv_pkg::*;
  io_addr_t io_addr;     // I/O register offset.
  logic     io_wr;       // One-cycle register write.
  logic     io_rd;       // One-cycle register read.
  byte_t    io_wdata;    // Write data.
  byte_t    io_rdata;    // Read data, valid the cycle after io_rd.
  logic     stall;       // Core must not issue while high.
  logic     irq;         // Ready interrupt level.
  logic     global_ie;   // Global interrupt enable of the core.
  logic     spm_busy;    // Flash self-programming in progress.
  logic     sleep_pd;    // Core is in power-down sleep.
  logic     pd_blocked;  // Timing clock keeps running in sleep.
  modport dev (input io_addr, io_wr, io_rd, io_wdata, global_ie,
               spm_busy, sleep_pd,
               output io_rdata, stall, irq, pd_blocked);
  modport core (output io_addr, io_wr, io_rd, io_wdata, global_ie,
                spm_busy, sleep_pd,
                input io_rdata, stall, irq, pd_blocked);
endinterface : nv_io_if
`default_nettype wire

// >>> src/nv_map.svh
`ifndef NV_MAP_SVH
`define NV_MAP_SVH
// ==========================================================
// Core-side I/O offsets of the nonvolatile access registers.
`define NV_CTRL_OFS    6'h1F
`define NV_VALUE_OFS   6'h20
`define NV_IDX_LO_OFS  6'h21
`define NV_IDX_HI_OFS  6'h22
// Control register bit positions.
`define NV_RD_BIT      0
`define NV_WBUSY_BIT   1
`define NV_ARM_BIT     2
`define NV_RIE_BIT     3
// Geometry and reset values.
`define NV_DEPTH       512
`define NV_IDX_W       9
`define NV_IDX_RST     9'h000
`define NV_VALUE_RST   8'h00
// Timing counts in core clocks.
`define NV_RD_STALL    3'h4
`define NV_WR_STALL    3'h2
`define NV_ARM_CYCLES  3'h4
// Self-timed write length in oscillator cycles, and its typical time.
`define NV_WR_OSC_CYC  27072
`define NV_WR_TIME_US  3300
// Host APB register offsets.
`define H_CMD_OFS      8'h00
`define H_ADDR_OFS     8'h04
`define H_WDATA_OFS    8'h08
`define H_STAT_OFS     8'h0C
`define H_CFG_OFS      8'h10
`define H_CMD_RD_BIT   0
`define H_CMD_WR_BIT   1
`define H_CFG_GIE_BIT  0
`define H_CFG_RIE_BIT  1
`define H_CFG_SLP_BIT  2
`endif

// >>> src/nv_pkg.sv
`default_nettype none
package nv_pkg;
  // ========================================================
  // Shared types.
  typedef logic [5:0] io_addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [8:0] index_t;
  typedef enum logic [3:0] {
    H_IDLE, H_POLL, H_PCAP, H_SPM, H_ILO, H_IHI, H_DATA,
    H_ARM, H_GO, H_RSTB, H_HOLD, H_RVAL, H_RCAP
  } host_state_t;
endpackage : nv_pkg
`default_nettype wire

// >>> src/nv_write_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
// ==========================================================
// Self-timed write duration counter, reset only at power-on.
module nv_write_timer #(
  parameter int unsigned WR_CYCLES = `NV_WR_OSC_CYC  // Write length.
) (
  input  wire logic pclk,    // Clock.
  input  wire logic por_n,   // Power-on reset, active low.
  input  wire logic start,   // One-cycle write start.
  output logic      busy_ff, // Write in progress.
  output logic      done_ff  // One-cycle pulse at write end.
);
  logic [15:0] cnt_ff;

  // Counts the write down and ends it with a done pulse.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cnt_ff  <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        cnt_ff  <= 16'(WR_CYCLES - 1);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == 16'h0000) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 16'h0001;
        end
      end
    end
  end
endmodule : nv_write_timer
`default_nettype wire
